// File: verilog/lsid_dispatch.v
// Legacy soft interrupt dispatch: method choice and redirect sequencer
// Functional notes
// - Bitmap bit 0 sends to legacy handler, 1 to protected handler.
// - Feature result bit 1 reports extension support.
// - Extension off, privilege 3: implicit call to protected vector handler.
// - Extension off, privilege below 3: protection fault.
// - Extension on, privilege below 3, bit 1: protection fault.
// - Extension on, privilege 3, bit 1: protected-mode handler.
// - Extension on, privilege 3, bit 0: redirect to legacy table.
// - Extension on, privilege below 3, bit 0: redirect with listed differences.
// - Redirect first pushes low 16 flag bits.
// - Then pushes code selector and low 16 pointer bits, no stack switch.
// - Privilege 3 redirect then clears interrupt enable and single step in the same cycle.
// - Fetch selector and pointer from table at address 0; upper pointer zeroed.
// - Stay in legacy mode throughout, then start the handler.
// - Interrupt return undoes the redirect and resumes the program.
// - Privilege below 3 redirect uses the virtual interrupt flag; the pending flag is not used.
// - Below 3: push flags with privilege 3, virtual flag as enable; clear it.
// - Bitmap is 32 bytes directly below I/O map base.
// - Hardware interrupts and exceptions ignore the bitmap.
`timescale 1ns/10ps
`default_nettype none
`include "lsid_defines.vh"

module lsid_dispatch #(
  parameter ADDR_W = 32
) (
  input  wire              mclk_i,
  input  wire              reset_n_i,
  input  wire              virtual_mode_ext_enable_i,
  input  wire              legacy_mode_i,
  input  wire              soft_int_i,
  input  wire              hw_event_i,
  input  wire              interrupt_return_instruction_i,
  input  wire [7:0]        vector_i,
  input  wire [255:0]      redir_bitmap_i,
  input  wire [15:0]       io_map_base_i,
  input  wire [31:0]       flags_register_i,
  input  wire [15:0]       code_sel_i,
  input  wire [31:0]       instruction_pointer_i,
  input  wire [31:0]       vec_entry_i,
  input  wire [15:0]       pop_data_i,
  output reg               feature_vme_o,
  output reg  [2:0]        method_o,
  output reg               method_valid_o,
  output reg               protection_fault_o,
  output reg               pm_handler_o,
  output reg               push_valid_o,
  output reg  [15:0]       push_data_o,
  output reg               pop_req_o,
  output reg  [ADDR_W-1:0] vec_addr_o,
  output reg               vec_rd_o,
  output reg  [31:0]       flags_register_o,
  output reg  [15:0]       code_sel_o,
  output reg  [31:0]       instruction_pointer_o,
  output reg               regs_load_o,
  output reg  [15:0]       bitmap_byte_addr_o,
  output reg               legacy_mode_o,
  output reg               busy_o
);

  // ---------------------------------------------------------------
  // States
  // ---------------------------------------------------------------
  localparam S_IDLE  = 7'h01;
  localparam S_PUSHF = 7'h02;
  localparam S_PUSHC = 7'h04;
  localparam S_PUSHI = 7'h08;
  localparam S_FETCH = 7'h10;
  localparam S_LOAD  = 7'h20;
  localparam S_POP   = 7'h40;

  reg  [6:0]  state_reg;
  reg  [1:0]  pop_cnt_reg;
  reg         virt_reg;
  reg  [31:0] flags_reg;
  reg  [15:0] sel_reg;
  reg  [15:0] ip_reg;
  wire [2:0]  meth;

  // Flags image pushed for a redirect
  function [15:0] push_image;
    input [31:0] fl;
    input        virt;
    reg   [15:0] img;
    begin
      img = fl[15:0];
      if (virt) begin
        img[`LSID_FL_IO_PRIVILEGE_LEVEL+1:`LSID_FL_IO_PRIVILEGE_LEVEL] = `LSID_IO_PRIVILEGE_LEVEL_MAX;
        img[`LSID_FL_IF] = fl[`LSID_FL_VIF];
      end
      push_image = img;
    end
  endfunction

  // ---------------------------------------------------------------
  // Method decode
  // ---------------------------------------------------------------
  lsid_method_sel u_sel (
    .ext_en_i     (virtual_mode_ext_enable_i),
    .io_privilege_level_i       (flags_register_i[`LSID_FL_IO_PRIVILEGE_LEVEL+1:`LSID_FL_IO_PRIVILEGE_LEVEL]),
    .bitmap_bit_i (redir_bitmap_i[vector_i]),
    .hw_event_i   (hw_event_i),
    .method_o     (meth)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg             <= S_IDLE;
      pop_cnt_reg           <= 2'h0;
      virt_reg              <= 1'b0;
      flags_reg             <= 32'h0;
      sel_reg               <= 16'h0;
      ip_reg                <= 16'h0;
      feature_vme_o         <= 1'b0;
      method_o              <= 3'h0;
      method_valid_o        <= 1'b0;
      protection_fault_o    <= 1'b0;
      pm_handler_o          <= 1'b0;
      push_valid_o          <= 1'b0;
      push_data_o           <= 16'h0;
      pop_req_o             <= 1'b0;
      vec_addr_o            <= {ADDR_W{1'b0}};
      vec_rd_o              <= 1'b0;
      flags_register_o      <= 32'h0;
      code_sel_o            <= 16'h0;
      instruction_pointer_o <= 32'h0;
      regs_load_o           <= 1'b0;
      bitmap_byte_addr_o    <= 16'h0;
      legacy_mode_o         <= 1'b0;
      busy_o                <= 1'b0;
    end else begin
      feature_vme_o      <= 1'b1;
      bitmap_byte_addr_o <= io_map_base_i - `LSID_BITMAP_BYTES;
      method_valid_o     <= 1'b0;
      protection_fault_o <= 1'b0;
      pm_handler_o       <= 1'b0;
      push_valid_o       <= 1'b0;
      pop_req_o          <= 1'b0;
      vec_rd_o           <= 1'b0;
      regs_load_o        <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          busy_o        <= 1'b0;
          legacy_mode_o <= legacy_mode_i;
          if (legacy_mode_i && (soft_int_i || hw_event_i)) begin
            method_o       <= meth;
            method_valid_o <= 1'b1;
            flags_reg      <= flags_register_i;
            sel_reg        <= code_sel_i;
            ip_reg         <= instruction_pointer_i[15:0];
            case (meth)
              `LSID_METH_FAULT_NOVM, `LSID_METH_FAULT_VM:
                protection_fault_o <= 1'b1;
              `LSID_METH_PM_CALL, `LSID_METH_PM_VM, `LSID_METH_HW:
                pm_handler_o <= 1'b1;
              `LSID_METH_REDIR, `LSID_METH_REDIR_VIRT: begin
                virt_reg  <= (meth == `LSID_METH_REDIR_VIRT);
                busy_o    <= 1'b1;
                state_reg <= S_PUSHF;
              end
              default: state_reg <= S_IDLE;
            endcase
          end else if (legacy_mode_i && interrupt_return_instruction_i) begin
            pop_cnt_reg <= 2'h0;
            busy_o      <= 1'b1;
            pop_req_o   <= 1'b1;
            state_reg   <= S_POP;
          end
        end
        S_PUSHF: begin
          push_valid_o <= 1'b1;
          push_data_o  <= push_image(flags_reg, virt_reg);
          state_reg    <= S_PUSHC;
        end
        S_PUSHC: begin
          push_valid_o <= 1'b1;
          push_data_o  <= sel_reg;
          state_reg    <= S_PUSHI;
        end
        S_PUSHI: begin
          push_valid_o <= 1'b1;
          push_data_o  <= ip_reg;
          vec_rd_o     <= 1'b1;
          vec_addr_o   <= {{(ADDR_W-10){1'b0}}, vector_i, 2'b00};
          state_reg    <= S_FETCH;
        end
        S_FETCH: begin
          flags_reg[`LSID_FL_TF] <= 1'b0;
          if (virt_reg)
            flags_reg[`LSID_FL_VIF] <= 1'b0;
          else
            flags_reg[`LSID_FL_IF] <= 1'b0;
          state_reg <= S_LOAD;
        end
        S_LOAD: begin
          flags_register_o      <= flags_reg;
          code_sel_o            <= vec_entry_i[31:16];
          instruction_pointer_o <= {16'h0, vec_entry_i[15:0]};
          regs_load_o           <= 1'b1;
          legacy_mode_o         <= 1'b1;
          state_reg             <= S_IDLE;
        end
        S_POP: begin
          // Pops arrive pointer, selector, flags
          case (pop_cnt_reg)
            2'h0: instruction_pointer_o <= {16'h0, pop_data_i};
            2'h1: code_sel_o <= pop_data_i;
            default: flags_register_o <= {flags_register_i[31:16], pop_data_i};
          endcase
          pop_cnt_reg <= pop_cnt_reg + 2'h1;
          if (pop_cnt_reg == `LSID_PUSH_STEPS - 2'h1) begin
            regs_load_o <= 1'b1;
            state_reg   <= S_IDLE;
          end else begin
            pop_req_o <= 1'b1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // lsid_dispatch
`default_nettype wire

// File: common/lsid_defines.vh
// Constants for the legacy soft interrupt dispatch block
`ifndef LSID_DEFINES_VH
`define LSID_DEFINES_VH

// Method codes, one per handling method
`define LSID_METH_PM_CALL    3'h1
`define LSID_METH_FAULT_NOVM 3'h2
`define LSID_METH_FAULT_VM   3'h3
`define LSID_METH_PM_VM      3'h4
`define LSID_METH_REDIR      3'h5
`define LSID_METH_REDIR_VIRT 3'h6
`define LSID_METH_HW         3'h7

// Flags register bit positions
`define LSID_FL_TF   8
`define LSID_FL_IF   9
`define LSID_FL_IO_PRIVILEGE_LEVEL 12
`define LSID_FL_VIF  19
`define LSID_FL_VIP  20

// Feature result bit advertising the extension
`define LSID_FEAT_VME_BIT 1

// Bitmap geometry and top I/O privilege level
`define LSID_BITMAP_BYTES 16'h0020
`define LSID_IO_PRIVILEGE_LEVEL_MAX     2'h3

// Push sequence step count
`define LSID_PUSH_STEPS 2'h3

`endif

// File: verilog/lsid_method_sel.v
// Method decoder for a software interrupt in virtual legacy mode
`timescale 1ns/10ps
`default_nettype none
`include "lsid_defines.vh"

module lsid_method_sel (
  input  wire         ext_en_i,
  input  wire [1:0]   io_privilege_level_i,
  input  wire         bitmap_bit_i,
  input  wire         hw_event_i,
  output reg  [2:0]   method_o
);

  always @* begin
    if (hw_event_i) begin
      method_o = `LSID_METH_HW;
    end else if (!ext_en_i) begin
      if (io_privilege_level_i == `LSID_IO_PRIVILEGE_LEVEL_MAX)
        method_o = `LSID_METH_PM_CALL;
      else
        method_o = `LSID_METH_FAULT_NOVM;
    end else if (bitmap_bit_i) begin
      if (io_privilege_level_i == `LSID_IO_PRIVILEGE_LEVEL_MAX)
        method_o = `LSID_METH_PM_VM;
      else
        method_o = `LSID_METH_FAULT_VM;
    end else begin
      if (io_privilege_level_i == `LSID_IO_PRIVILEGE_LEVEL_MAX)
        method_o = `LSID_METH_REDIR;
      else
        method_o = `LSID_METH_REDIR_VIRT;
    end
  end

endmodule // lsid_method_sel
`default_nettype wire

// File: test/lsid_dispatch_asserts.sv
// Concurrent checks on the dispatch block ports
`timescale 1ns/10ps
`default_nettype none
module lsid_dispatch_asserts #(
  parameter ADDR_W = 32
) (
  input wire logic              mclk_i,
  input wire logic              reset_n_i,
  input wire logic              virtual_mode_ext_enable_i,
  input wire logic              legacy_mode_i,
  input wire logic              soft_int_i,
  input wire logic              hw_event_i,
  input wire logic [7:0]        vector_i,
  input wire logic [255:0]      redir_bitmap_i,
  input wire logic [15:0]       io_map_base_i,
  input wire logic [31:0]       flags_register_i,
  input wire logic              feature_vme_o,
  input wire logic [2:0]        method_o,
  input wire logic              method_valid_o,
  input wire logic              protection_fault_o,
  input wire logic              pm_handler_o,
  input wire logic              push_valid_o,
  input wire logic [ADDR_W-1:0] vec_addr_o,
  input wire logic              vec_rd_o,
  input wire logic [15:0]       bitmap_byte_addr_o,
  input wire logic              busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Accepted software request and its decision inputs
  wire rq = legacy_mode_i && soft_int_i && !hw_event_i && !busy_o;
  wire ex = virtual_mode_ext_enable_i;
  wire p3 = flags_register_i[13:12] == 2'h3;
  wire bb = redir_bitmap_i[vector_i];
  property p_m1; rq && !ex && p3 |=> method_valid_o && method_o == 3'h1 && pm_handler_o; endproperty
  a_m1: assert property (p_m1) else $error("method one not taken");
  property p_m2; rq && !ex && !p3 |=> protection_fault_o && method_o == 3'h2; endproperty
  a_m2: assert property (p_m2) else $error("method two not taken");
  property p_m3; rq && ex && !p3 && bb |=> protection_fault_o && method_o == 3'h3; endproperty
  a_m3: assert property (p_m3) else $error("method three not taken");
  property p_m4; rq && ex && p3 && bb |=> pm_handler_o && method_o == 3'h4; endproperty
  a_m4: assert property (p_m4) else $error("method four not taken");
  property p_m5; rq && ex && p3 && !bb |=> method_o == 3'h5 ##1 push_valid_o [*3] ##1 !push_valid_o;
  endproperty
  a_m5: assert property (p_m5) else $error("redirect push train wrong");
  property p_m6; rq && ex && !p3 && !bb |=> method_o == 3'h6 ##3 vec_rd_o; endproperty
  a_m6: assert property (p_m6) else $error("method six not taken");
  property p_hw; legacy_mode_i && hw_event_i && !busy_o |=> method_o == 3'h7 && pm_handler_o
    && !protection_fault_o; endproperty
  a_hw: assert property (p_hw) else $error("hardware event misrouted");
  property p_feat; $past(reset_n_i) |-> feature_vme_o; endproperty
  a_feat: assert property (p_feat) else $error("feature bit low");
  property p_vec; vec_rd_o |-> vec_addr_o == (ADDR_W'(vector_i) << 2); endproperty
  a_vec: assert property (p_vec) else $error("table address wrong");
  property p_bmap; $past(reset_n_i) |-> bitmap_byte_addr_o == $past(io_map_base_i) - 16'h0020;
  endproperty
  a_bmap: assert property (p_bmap) else $error("bitmap address wrong");
  c_m5: cover property (rq && ex && p3 && !bb);
  c_m6: cover property (rq && ex && !p3 && !bb);
  c_hw: cover property (hw_event_i && soft_int_i && legacy_mode_i);
endmodule // lsid_dispatch_asserts
`default_nettype wire

// File: test/lsid_dispatch_bench.sv
// Self-checking bench for the dispatch block
`timescale 1ns/10ps
`default_nettype none
module lsid_dispatch_bench;
  logic mclk_i = 0, reset_n_i = 0, virtual_mode_ext_enable_i = 0, legacy_mode_i = 1;
  logic soft_int_i = 0, hw_event_i = 0, interrupt_return_instruction_i = 0;
  logic [7:0]   vector_i = 8'h10;
  logic [255:0] redir_bitmap_i = 256'h1 << 8'h21;
  logic [15:0]  io_map_base_i = 16'h0068, code_sel_i = 16'h1a2b, pop_data_i = 16'h0;
  logic [31:0]  flags_register_i = 32'h0, instruction_pointer_i = 32'h5555_7788;
  logic [31:0]  vec_entry_i = 32'h1234_0abc;
  wire  [31:0]  vec_addr_o, flags_register_o, instruction_pointer_o;
  wire  [15:0]  push_data_o, code_sel_o, bitmap_byte_addr_o;
  wire  [2:0]   method_o;
  wire          feature_vme_o, method_valid_o, protection_fault_o, pm_handler_o, push_valid_o;
  wire          pop_req_o, vec_rd_o, regs_load_o, legacy_mode_o, busy_o;
  logic [15:0]  pq[$];
  logic [15:0]  pv[3] = '{16'h0246, 16'h1357, 16'h0a5a};
  logic [31:0]  fo, ipo, adr, fl;
  logic [15:0]  cso;
  logic [2:0]   meth;
  logic         flt, pmh;
  int           errors = 0, checked = 0, pk, i;
  int           iv[6] = '{3, 2, 1, 3, 3, 0};
  lsid_dispatch dut (.mclk_i, .reset_n_i, .virtual_mode_ext_enable_i, .legacy_mode_i,
    .soft_int_i, .hw_event_i, .interrupt_return_instruction_i, .vector_i, .redir_bitmap_i,
    .io_map_base_i, .flags_register_i, .code_sel_i, .instruction_pointer_i, .vec_entry_i,
    .pop_data_i, .feature_vme_o, .method_o, .method_valid_o, .protection_fault_o,
    .pm_handler_o, .push_valid_o, .push_data_o, .pop_req_o, .vec_addr_o, .vec_rd_o,
    .flags_register_o, .code_sel_o, .instruction_pointer_o, .regs_load_o,
    .bitmap_byte_addr_o, .legacy_mode_o, .busy_o);
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Pulse one request, then record every answer until idle
  task automatic run(input logic s, input logic h, input logic r);
    @(posedge mclk_i);
    soft_int_i <= s;
    hw_event_i <= h;
    interrupt_return_instruction_i <= r;
    @(posedge mclk_i);
    soft_int_i <= 0;
    hw_event_i <= 0;
    interrupt_return_instruction_i <= 0;
    pq = {};
    {meth, flt, pmh, adr, fo, ipo, cso, pk} = '0;
    for (int n = 0; n < 14; n++) begin
      #1;
      if (method_valid_o) {meth, flt, pmh} = {method_o, protection_fault_o, pm_handler_o};
      if (push_valid_o) pq.push_back(push_data_o);
      if (vec_rd_o) adr = vec_addr_o;
      if (pop_req_o && pk < 3) begin
        pop_data_i <= pv[pk];
        pk++;
      end
      if (regs_load_o) {fo, cso, ipo} = {flags_register_o, code_sel_o, instruction_pointer_o};
      if (n > 1 && !busy_o) break;
      @(posedge mclk_i);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1;
    repeat (2) @(posedge mclk_i);
    #1;
    chk(feature_vme_o, 1, "feature");
    chk(bitmap_byte_addr_o, 16'h0048, "bitmap address");
    for (i = 0; i < 6; i++) begin
      fl = 32'h0008_0100 | (iv[i] << 12);
      @(posedge mclk_i);
      virtual_mode_ext_enable_i <= (i > 1);
      flags_register_i <= fl;
      vector_i <= (i == 2 || i == 3) ? 8'h21 : 8'h10;
      run(1, 0, 0);
      chk(meth, i + 1, "method");
      chk(flt, i == 1 || i == 2, "fault");
      chk(pmh, i == 0 || i == 3, "handler");
      if (i > 3) begin
        chk(pq.size(), 3, "push count");
        chk(pq[0], i == 4 ? fl[15:0] : fl[15:0] | 16'h3200, "flags image");
        chk(pq[1], code_sel_i, "selector push");
        chk(pq[2], instruction_pointer_i[15:0], "pointer push");
        chk(adr, 32'h40, "table address");
        chk(cso, vec_entry_i[31:16], "selector load");
        chk(ipo, {16'h0, vec_entry_i[15:0]}, "pointer load");
        chk(fo, fl & ~(i == 4 ? 32'h300 : 32'h0008_0100), "flags out");
        chk(legacy_mode_o, 1, "legacy mode");
      end
      $display("method test %0d done", i + 1);
    end
    run(0, 0, 1);
    chk(ipo[15:0], pv[0], "pointer restore");
    chk(cso, pv[1], "selector restore");
    chk(fo, {fl[31:16], pv[2]}, "flags restore");
    $display("return test done");
    run(1, 1, 0);
    chk({meth, flt, pmh}, 5'b111_0_1, "hardware event");
    $display("hardware test done");
    @(posedge mclk_i);
    legacy_mode_i <= 0;
    run(1, 0, 0);
    chk(meth, 0, "outside legacy mode");
    $display("refusal test done");
    close_out;
  end
  initial begin
    #5000;
    errors++;
    close_out;
  end
endmodule // lsid_dispatch_bench
bind lsid_dispatch lsid_dispatch_asserts #(.ADDR_W(ADDR_W)) u_chk (.mclk_i, .reset_n_i,
  .virtual_mode_ext_enable_i, .legacy_mode_i, .soft_int_i, .hw_event_i, .vector_i,
  .redir_bitmap_i, .io_map_base_i, .flags_register_i, .feature_vme_o, .method_o,
  .method_valid_o, .protection_fault_o, .pm_handler_o, .push_valid_o, .vec_addr_o,
  .vec_rd_o, .bitmap_byte_addr_o, .busy_o);
`default_nettype wire
